// file: adcp_port.sv
// parallel sample output port of a delta-sigma converter, with status registers
`timescale 1ns/100ps
`default_nettype none
module adcp_port #(
    parameter int DATA_W = adcp_pkg::DATA_W // sample width
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic double_rate_sel,
    input wire logic [2:0] buffer_depth_sel,
    input wire logic power_down_n,
    input wire logic internal_ref_en_n,
    input wire logic [DATA_W-1:0] mod_data,
    input wire logic mod_over,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic sample_strobe_n,
    output logic [DATA_W-1:0] dout,
    output logic dout_oe,
    output logic overrange_flag,
    output logic internal_ref_on
);
    adcp_pkg::adcp_regs_t r_q; // registered state
    adcp_pkg::adcp_regs_t r_d; // next state

    logic [15:0] filt_result; // latest average from the filter
    logic filt_ovr; // overrange seen during that window
    logic filt_clear; // wipe filter history
    logic filt_dump; // close the current window
    logic [1:0] filt_shift; // divide by the ratio
    logic [2:0] osr_last; // last phase of a strobe period
    logic [2:0] half_last; // last low phase of a strobe period
    logic [15:0] code; // word to present at the next fall
    logic fall; // strobe falls at the coming edge
    logic [2:0] irq_ev; // events raised this cycle
    logic [2:0] irq_clr; // bits software clears this cycle
    logic [5:0] settle_next; // settle counter plus one

    // period and divider follow the static rate pin
    always_comb begin
        if (r_q.dbl) begin
            osr_last = adcp_pkg::OSR_LAST_DOUBLE;
            half_last = adcp_pkg::HALF_LAST_DOUBLE;
            filt_shift = adcp_pkg::SHIFT_DOUBLE;
        end else begin
            osr_last = adcp_pkg::OSR_LAST_NORMAL;
            half_last = adcp_pkg::HALF_LAST_NORMAL;
            filt_shift = adcp_pkg::SHIFT_NORMAL;
        end
    end

    // the filter closes its window one clock before the strobe falls,
    // so its registered result is ready exactly when the bus loads
    assign filt_clear = (r_q.st != adcp_pkg::ADCP_RUN);
    assign filt_dump = (r_q.st == adcp_pkg::ADCP_RUN) && (r_q.phase == osr_last - 3'h1);

    adcp_decim adcp_decim_i (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(filt_clear),
        .dump(filt_dump),
        .shift(filt_shift),
        .mod_data(mod_data[15:0]),
        .mod_over(mod_over),
        .result(filt_result),
        .res_ovr(filt_ovr)
    );

    // out of range pins the word to the end of the scale by its sign
    always_comb begin
        if (filt_ovr) begin
            code = filt_result[15] ? adcp_pkg::CODE_MIN : adcp_pkg::CODE_MAX;
        end else begin
            code = filt_result;
        end
    end

    // next state of the whole port
    always_comb begin
        r_d = r_q;
        fall = 1'b0;
        settle_next = r_q.settle_cnt + 6'h1;
        irq_ev = '0;
        irq_clr = '0;
        // static pins sampled every clock
        r_d.dbl = double_rate_sel;
        r_d.depth = buffer_depth_sel;
        r_d.ref_on = ~internal_ref_en_n & power_down_n;
        // bus drivers on only with both selects low and power up
        r_d.dout_oe = ~cs_n & ~rd_n & power_down_n;
        if (!power_down_n) begin
            // sampling stopped, strobe parked high; register port still answers
            r_d.st = adcp_pkg::ADCP_DOWN;
            r_d.phase = '0;
            r_d.strobe_n = 1'b1;
            r_d.dout = adcp_pkg::DOUT_RST;
            r_d.ovr = 1'b0;
            r_d.settle_cnt = '0;
            r_d.settled = 1'b0;
        end else if (!reset_n) begin
            // filter held clear, outputs forced
            r_d.st = adcp_pkg::ADCP_HELD;
            r_d.phase = '0;
            r_d.strobe_n = 1'b1;
            r_d.dout = adcp_pkg::DOUT_RST;
            r_d.ovr = 1'b0;
            r_d.settle_cnt = '0;
            r_d.settled = 1'b0;
        end else begin
            unique case (r_q.st)
                adcp_pkg::ADCP_DOWN, adcp_pkg::ADCP_HELD: begin
                    // first window starts from an empty filter
                    r_d.st = adcp_pkg::ADCP_RUN;
                    r_d.phase = '0;
                end
                adcp_pkg::ADCP_RUN: begin
                    // a rate change mid-period wraps cleanly
                    if (r_q.phase >= osr_last) begin
                        r_d.phase = '0;
                        r_d.strobe_n = 1'b0;
                        r_d.dout = code;
                        r_d.ovr = filt_ovr;
                        fall = 1'b1;
                    end else begin
                        r_d.phase = r_q.phase + 3'h1;
                        if (r_q.phase == half_last) begin
                            r_d.strobe_n = 1'b1;
                        end
                    end
                end
                default: begin
                    r_d.st = adcp_pkg::ADCP_HELD;
                end
            endcase
        end
        // count strobe cycles until the filter has settled
        if (fall && !r_q.settled) begin
            r_d.settle_cnt = settle_next;
            if (settle_next == adcp_pkg::SETTLE_STROBES) begin
                r_d.settled = 1'b1;
                irq_ev[adcp_pkg::IRQ_SETTLED] = 1'b1;
            end
        end
        irq_ev[adcp_pkg::IRQ_SAMPLE] = fall;
        irq_ev[adcp_pkg::IRQ_OVER] = fall & filt_ovr;
        // register writes
        if (reg_wr) begin
            if (reg_addr == adcp_pkg::REG_IRQ_STATUS) begin
                irq_clr = reg_wdata[2:0];
            end
            if (reg_addr == adcp_pkg::REG_IRQ_MASK) begin
                r_d.irq_mask = reg_wdata[2:0];
            end
        end
        // an event in the clearing cycle survives the clear
        r_d.irq_stat = (r_q.irq_stat & ~irq_clr) | irq_ev;
        r_d.irq = |(r_d.irq_stat & r_d.irq_mask);
        // read data stand for one cycle only, zero otherwise
        r_d.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                adcp_pkg::REG_IRQ_STATUS: begin
                    r_d.rdata[2:0] = r_q.irq_stat;
                end
                adcp_pkg::REG_IRQ_MASK: begin
                    r_d.rdata[2:0] = r_q.irq_mask;
                end
                adcp_pkg::REG_PORT_STATE: begin
                    r_d.rdata[adcp_pkg::ST_SETTLED_BIT] = r_q.settled;
                    r_d.rdata[adcp_pkg::ST_COUNT_LSB +: 6] = r_q.settle_cnt;
                    r_d.rdata[adcp_pkg::ST_DEPTH_LSB +: 3] = r_q.depth;
                    r_d.rdata[adcp_pkg::ST_DOUBLE_BIT] = r_q.dbl;
                    r_d.rdata[adcp_pkg::ST_REF_BIT] = r_q.ref_on;
                    r_d.rdata[adcp_pkg::ST_DOWN_BIT] = (r_q.st == adcp_pkg::ADCP_DOWN);
                end
                default: begin
                    // unmapped address reads as zero
                    r_d.rdata = '0;
                end
            endcase
        end
    end

    // one register stage; every output comes from here
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r_q.st <= adcp_pkg::ADCP_HELD;
            r_q.phase <= '0;
            r_q.strobe_n <= 1'b1;
            r_q.dout <= adcp_pkg::DOUT_RST;
            r_q.dout_oe <= 1'b0;
            r_q.ovr <= 1'b0;
            r_q.ref_on <= 1'b0;
            r_q.settle_cnt <= '0;
            r_q.settled <= 1'b0;
            r_q.irq_stat <= '0;
            r_q.irq_mask <= adcp_pkg::IRQ_MASK_RST;
            r_q.irq <= 1'b0;
            r_q.rdata <= '0;
            r_q.depth <= '0;
            r_q.dbl <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from flops; the host samples between falls
    assign sample_strobe_n = r_q.strobe_n;
    assign dout = r_q.dout;
    assign dout_oe = r_q.dout_oe;
    assign overrange_flag = r_q.ovr;
    assign internal_ref_on = r_q.ref_on;
    assign irq = r_q.irq;
    assign reg_rdata = r_q.rdata;
endmodule : adcp_port
`default_nettype wire

// file: adcp_pkg.sv
// shared constants and types of the parallel sample output port
package adcp_pkg;
    // sample word
    localparam int DATA_W = 16;
    localparam logic [15:0] CODE_MAX = 16'h7fff;
    localparam logic [15:0] CODE_MIN = 16'h8000;
    localparam logic [15:0] DOUT_RST = 16'h0000;
    // oversampling ratios, last phase of the strobe period (period in clocks minus one)
    localparam logic [2:0] OSR_LAST_NORMAL = 3'h7;
    localparam logic [2:0] OSR_LAST_DOUBLE = 3'h3;
    localparam logic [2:0] HALF_LAST_NORMAL = 3'h3;
    localparam logic [2:0] HALF_LAST_DOUBLE = 3'h1;
    localparam logic [1:0] SHIFT_NORMAL = 2'h3;
    localparam logic [1:0] SHIFT_DOUBLE = 2'h2;
    // filter settling, in strobe cycles
    localparam logic [5:0] SETTLE_STROBES = 6'h2f;
    // register port
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_MASK = 4'h1;
    localparam logic [3:0] REG_PORT_STATE = 4'h2;
    // interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_SAMPLE = 0;
    localparam int IRQ_OVER = 1;
    localparam int IRQ_SETTLED = 2;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // port state register fields
    localparam int ST_SETTLED_BIT = 0;
    localparam int ST_COUNT_LSB = 1;
    localparam int ST_DEPTH_LSB = 7;
    localparam int ST_DOUBLE_BIT = 10;
    localparam int ST_REF_BIT = 11;
    localparam int ST_DOWN_BIT = 12;
    // operating states
    typedef enum logic [1:0] {
        ADCP_HELD,
        ADCP_RUN,
        ADCP_DOWN
    } adcp_state_t;
    // all state of the port top
    typedef struct packed {
        adcp_state_t st;
        logic [2:0] phase;
        logic strobe_n;
        logic [15:0] dout;
        logic dout_oe;
        logic ovr;
        logic ref_on;
        logic [5:0] settle_cnt;
        logic settled;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        logic [2:0] depth;
        logic dbl;
    } adcp_regs_t;
    // state of the decimator
    typedef struct packed {
        logic [18:0] acc;
        logic acc_ovr;
        logic [15:0] result;
        logic res_ovr;
    } adcp_decim_t;
endpackage : adcp_pkg

// file: adcp_decim.sv
// boxcar decimating filter: sums modulator words over one output window
`timescale 1ns/100ps
`default_nettype none
module adcp_decim (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic dump,
    input wire logic [1:0] shift,
    input wire logic [15:0] mod_data,
    input wire logic mod_over,
    output logic [15:0] result,
    output logic res_ovr
);
    adcp_pkg::adcp_decim_t r_q; // registered state
    adcp_pkg::adcp_decim_t r_d; // next state
    logic [18:0] sum; // running sum including this clock
    logic [18:0] scaled; // sum divided by the ratio

    // accumulate, then hand the average over at the end of a window
    always_comb begin
        r_d = r_q;
        sum = r_q.acc + {{3{mod_data[15]}}, mod_data};
        scaled = $signed(sum) >>> shift;
        if (clear) begin
            // filter history wiped while held or powered down
            r_d = '0;
        end else if (dump) begin
            r_d.result = scaled[15:0];
            r_d.res_ovr = r_q.acc_ovr | mod_over;
            r_d.acc = '0;
            r_d.acc_ovr = 1'b0;
        end else begin
            r_d.acc = sum;
            r_d.acc_ovr = r_q.acc_ovr | mod_over;
        end
    end

    // one register stage for the whole filter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign result = r_q.result;
    assign res_ovr = r_q.res_ovr;
endmodule : adcp_decim
`default_nettype wire

// file: adcp_port_asserts.sv
// checker of strobe shape, bus enable and forcing at the port pins
`timescale 1ns/100ps
`default_nettype none
module adcp_port_asserts #(
    parameter int DATA_W = 16 // sample width
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic double_rate_sel,
    input wire logic power_down_n,
    input wire logic internal_ref_en_n,
    input wire logic sample_strobe_n,
    input wire logic [DATA_W-1:0] dout,
    input wire logic dout_oe,
    input wire logic overrange_flag,
    input wire logic internal_ref_on
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // strobe shape only holds while the filter runs; rate pin moves only under reset
    strobe_low_a: assert property (disable iff (sys_rst || !reset_n || !power_down_n)
        $fell(sample_strobe_n) && !double_rate_sel |-> !sample_strobe_n [*4] ##1 sample_strobe_n)
        else $error("strobe low time wrong");
    strobe_high_a: assert property (disable iff (sys_rst || !reset_n || !power_down_n)
        $rose(sample_strobe_n) && !double_rate_sel |-> sample_strobe_n [*4] ##1 !sample_strobe_n)
        else $error("strobe high time wrong");
    double_rate_a: assert property (disable iff (sys_rst || !reset_n || !power_down_n)
        $fell(sample_strobe_n) && double_rate_sel |-> !sample_strobe_n [*2] ##1 sample_strobe_n [*2] ##1 !sample_strobe_n)
        else $error("double rate strobe wrong");
    // the word may only move where the strobe falls
    word_hold_a: assert property (disable iff (sys_rst || !reset_n || !power_down_n)
        !$fell(sample_strobe_n) |-> $stable(dout) && $stable(overrange_flag))
        else $error("word changed off strobe fall");
    reset_force_a: assert property (!reset_n |=> sample_strobe_n && dout == '0 && !overrange_flag)
        else $error("reset did not force outputs");
    bus_drive_a: assert property (!cs_n && !rd_n && power_down_n |=> dout_oe)
        else $error("bus not driven");
    bus_float_a: assert property (cs_n || rd_n |=> !dout_oe)
        else $error("bus not released");
    power_down_a: assert property (!power_down_n |=> sample_strobe_n && !dout_oe && !internal_ref_on)
        else $error("power down not forced");
    ref_select_a: assert property (power_down_n |=> internal_ref_on == !$past(internal_ref_en_n))
        else $error("reference state wrong");
endmodule : adcp_port_asserts
bind adcp_port adcp_port_asserts #(.DATA_W(DATA_W)) adcp_port_asserts_i (.ref_clk, .sys_rst, .reset_n,
    .cs_n, .rd_n, .double_rate_sel, .power_down_n, .internal_ref_en_n, .sample_strobe_n, .dout, .dout_oe,
    .overrange_flag, .internal_ref_on);
`default_nettype wire

// file: adcp_host_model.sv
// host model: takes each word one edge after the strobe falls
`timescale 1ns/100ps
`default_nettype none
module adcp_host_model (
    input wire logic ref_clk,
    input wire logic sample_strobe_n,
    input wire logic [15:0] dout,
    input wire logic dout_oe,
    input wire logic overrange_flag,
    output logic got,
    output logic [16:0] word
);
    logic last_q; // strobe one edge ago
    logic [15:0] seen; // bus as the host sees it
    // a released bus shows the inverse of the last word, never a stale copy
    always_comb seen = dout_oe ? dout : ~word[15:0];
    // capture between this fall and the next
    always_ff @(posedge ref_clk) begin
        last_q <= sample_strobe_n;
        got <= last_q && !sample_strobe_n && dout_oe;
        if (last_q && !sample_strobe_n) begin
            word <= {overrange_flag, seen};
        end
    end
endmodule : adcp_host_model
`default_nettype wire

// file: adcp_port_tb_top.sv
// self-checking bench of the parallel sample output port
`timescale 1ns/100ps
`default_nettype none
module adcp_port_tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reset_n = 1'b0;
    logic cs_n = 1'b0;
    logic rd_n = 1'b0;
    logic double_rate_sel = 1'b0;
    logic [2:0] buffer_depth_sel = 3'h0;
    logic power_down_n = 1'b1;
    logic internal_ref_en_n = 1'b0;
    logic [15:0] mod_data = 16'h0000;
    logic mod_over = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq, sample_strobe_n, dout_oe, overrange_flag, internal_ref_on, got, rd_q;
    logic [15:0] dout;
    logic [16:0] word;
    logic [16:0] samp_q[$]; // expected words with overrange on top
    logic [63:0] reg_q[$]; // mask and expected read value
    logic [63:0] note;
    int miscompares = 0;
    int checked = 0;
    always #12.5 ref_clk = ~ref_clk;
    adcp_port adcp_port_i (.ref_clk, .sys_rst, .reset_n, .cs_n, .rd_n, .double_rate_sel, .buffer_depth_sel,
        .power_down_n, .internal_ref_en_n, .mod_data, .mod_over, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .sample_strobe_n, .dout, .dout_oe, .overrange_flag, .internal_ref_on);
    adcp_host_model adcp_host_model_i (.ref_clk, .sample_strobe_n, .dout, .dout_oe, .overrange_flag, .got, .word);
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic conclude;
        $display("counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    // bounded wait for a strobe level; running out ends the run
    task automatic wait_lvl(input logic v);
        for (int n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (sample_strobe_n === v) return;
        end
        miscompares++;
        conclude();
    endtask : wait_lvl
    task automatic wait_fall;
        wait_lvl(1'b1);
        wait_lvl(1'b0);
    endtask : wait_fall
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // one idle edge, so a following call never raises the strobe again in this step
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        reg_q.push_back({m, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        // one idle edge, so back to back reads never reassign the strobe in one step
        @(posedge ref_clk);
    endtask : rd
    // expected port state: down, reference, rate, depth, settled
    function automatic logic [31:0] st(input logic s);
        return {19'h0, !power_down_n, !internal_ref_en_n && power_down_n, double_rate_sel, buffer_depth_sel, 6'h0, s};
    endfunction : st
    // read answers stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_q === 1'b1 && reg_q.size() > 0) begin
            note = reg_q.pop_front();
            check(reg_rdata & note[63:32], note[31:0]);
        end
        rd_q <= reg_rd;
    end
    // words from the host model, against the oldest note
    always @(negedge ref_clk) begin
        if (got === 1'b1 && samp_q.size() > 0)
            check({15'h0, word}, {15'h0, samp_q.pop_front()});
    end
    initial begin
        logic [15:0] v;
        logic ov;
        void'($urandom(32'h19809588));
        cyc(16);
        sys_rst <= 1'b0;
        rd(4'hf, 32'hffffffff, 32'h0);
        wr(4'h1, 32'h5);
        rd(4'h1, 32'h7, 32'h5);
        for (int d = 1; d >= 0; d--) begin
            reset_n <= 1'b0;
            double_rate_sel <= d[0];
            buffer_depth_sel <= 3'($urandom);
            cyc(3);
            reset_n <= 1'b1;
            repeat (46) wait_fall();
            cyc(1);
            rd(adcp_pkg::REG_PORT_STATE, 32'h1f81, st(1'b0));
            wait_fall();
            cyc(1);
            rd(adcp_pkg::REG_PORT_STATE, 32'h1f81, st(1'b1));
            for (int k = 0; k < 5; k++) begin
                v = (k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : 16'($urandom);
                // third word always out of range, so the clamp path is always exercised
                ov = (k == 2) || ((k > 2) && $urandom_range(1, 0));
                mod_data <= v;
                mod_over <= ov;
                wait_fall();
                wait_fall();
                cyc(1);
                samp_q.push_back(ov ? (v[15] ? {1'b1, 16'h8000} : {1'b1, 16'h7fff}) : {1'b0, v});
                wait_fall();
            end
            $display("sample test at rate %0d done", d);
        end
        // sample, overrange and settled events have all been raised by now
        rd(adcp_pkg::REG_IRQ_STATUS, 32'h7, 32'h7);
        wr(4'h1, 32'h1);
        wait_fall();
        cyc(1);
        check({31'h0, irq}, 32'h1);
        wr(4'h0, 32'h7);
        wr(4'h1, 32'h0);
        rd(4'h0, 32'h1, 32'h0);
        cyc(1);
        check({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        for (int k = 0; k < 4; k++) begin
            {cs_n, rd_n} <= k[1:0];
            cyc(2);
            check({31'h0, dout_oe}, {31'h0, k == 0});
        end
        power_down_n <= 1'b0;
        cyc(3);
        check({30'h0, sample_strobe_n, internal_ref_on}, 32'h2);
        rd(adcp_pkg::REG_PORT_STATE, 32'h1800, 32'h1000);
        power_down_n <= 1'b1;
        internal_ref_en_n <= 1'b1;
        cyc(3);
        check({31'h0, internal_ref_on}, 32'h0);
        $display("pin test done");
        conclude();
    end
endmodule : adcp_port_tb_top
`default_nettype wire
